// ---- dual_pulse_modulator.sv ----
`timescale 1ns/100ps
`default_nettype none
module dual_pulse_modulator
  import pwm_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // apb slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // pulse pins
  output var  logic [1:0]  pulse_out,
  output var  logic [1:0]  pulse_oe,
  // interrupt
  output var  logic        irq
);

  ////////////////////////////////////////////////////////////////////////////
  pwm_state_t s;
  pwm_state_t next_s;
  logic       wr_acc;
  logic       rd_setup;
  logic       tick;
  logic       wrap;
  logic       wr_ctl;
  logic [7:0] cmp [2];
  logic [7:0] new_ctl;

  assign wr_acc   = psel && penable && pwrite && s.pready;
  assign rd_setup = psel && !penable;
  assign pslverr  = 1'b0;
  assign prdata   = s.prdata;
  assign pready   = s.pready;
  assign pulse_out = s.pin_out;
  assign pulse_oe  = s.pin_oe;
  assign irq       = s.irq;
  assign cmp[0]    = s.channel0_compare;
  assign cmp[1]    = s.channel1_compare;
  assign wr_ctl    = wr_acc && paddr == ADDR_CONTROL;
  assign new_ctl   = pwdata[7:0];

  // prescaler expiry; counter advances once per reload plus one clocks
  assign tick = s.counter_enable_clear && s.prescale == CMP_HIGH;
  assign wrap = tick && s.count == CNT_TOP;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_s = s;
    // no wait state: setup, then access with pready high
    next_s.pready = rd_setup;
    next_s.prdata = DATA_ZERO;
    if (rd_setup && !pwrite) begin
      case (paddr)
        ADDR_CONTROL: begin
          next_s.prdata[CTL_OVF] = s.counter_overflow_flag;
          next_s.prdata[CTL_EN]  = s.counter_enable_clear;
          next_s.prdata[CTL_OE1] = s.channel1_output_enable;
          next_s.prdata[CTL_OE0] = s.channel0_output_enable;
        end
        // reload value reads back, prescale count hidden
        ADDR_PERIOD:   next_s.prdata[7:0] = s.period_reload_value;
        ADDR_CMP0:     next_s.prdata[7:0] = s.channel0_compare;
        ADDR_CMP1:     next_s.prdata[7:0] = s.channel1_compare;
        ADDR_IRQ_STAT: next_s.prdata[IRQ_OVF] = s.irq_status;
        ADDR_IRQ_MASK: next_s.prdata[IRQ_OVF] = s.irq_mask;
        default:       next_s.prdata = DATA_ZERO;
      endcase
    end
    if (wr_acc) begin
      case (paddr)
        ADDR_CONTROL: begin
          next_s.counter_enable_clear   = new_ctl[CTL_EN];
          next_s.channel1_output_enable = new_ctl[CTL_OE1];
          next_s.channel0_output_enable = new_ctl[CTL_OE0];
        end
        ADDR_PERIOD:   next_s.period_reload_value = new_ctl;
        ADDR_CMP0:     next_s.channel0_compare = new_ctl;
        ADDR_CMP1:     next_s.channel1_compare = new_ctl;
        ADDR_IRQ_MASK: next_s.irq_mask = new_ctl[IRQ_OVF];
        default:       next_s.irq_mask = s.irq_mask;
      endcase
    end
    // software writes zero to clear the flag, one to clear the status bit; a set in the same cycle wins
    if (wr_ctl && !new_ctl[CTL_OVF]) begin
      next_s.counter_overflow_flag = 1'b0;
    end
    if (wr_acc && paddr == ADDR_IRQ_STAT && pwdata[IRQ_OVF]) begin
      next_s.irq_status = 1'b0;
    end
    // enable low holds counter clear and prescaler loaded
    if (!s.counter_enable_clear) begin
      next_s.prescale = ~s.period_reload_value;
      next_s.count    = CNT_ZERO;
    end else if (tick) begin
      // reload on overflow of the prescaler
      next_s.prescale = ~s.period_reload_value;
      next_s.count    = wrap ? CNT_ZERO : s.count + 8'h01;
    end else begin
      next_s.prescale = s.prescale + 8'h01;
    end
    if (wrap) begin
      next_s.counter_overflow_flag = 1'b1;
      next_s.irq_status            = 1'b1;
    end
    for (int i = 0; i < 2; i++) begin
      // fixed levels at 00h and ffh
      if (cmp[i] == CMP_LOW) begin
        next_s.pulse[i] = 1'b0;
      end else if (cmp[i] == CMP_HIGH) begin
        next_s.pulse[i] = 1'b1;
      // high at zero or while held clear
      end else if (!s.counter_enable_clear || s.count == CNT_ZERO) begin
        next_s.pulse[i] = 1'b1;
      end else if (s.count == cmp[i]) begin
        next_s.pulse[i] = 1'b0;
      end
    end
    next_s.pin_out = s.pulse;
    next_s.pin_oe  = {s.channel1_output_enable, s.channel0_output_enable};
    next_s.irq     = s.irq_status && s.irq_mask;
  end

  ////////////////////////////////////////////////////////////////////////////
  // synchronous chip reset; state holds whenever the clock stops
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s <= '0;
      s.period_reload_value <= PERIOD_RESET;
      s.channel0_compare    <= CMP_RESET;
      s.channel1_compare    <= CMP_RESET;
      {s.counter_overflow_flag, s.counter_enable_clear,
       s.channel1_output_enable, s.channel0_output_enable} <= CTL_RESET[3:0];
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  sequence s_wrap;
    tick && s.count == CNT_TOP;
  endsequence

  property p_ovf_set;
    @(posedge ref_clk) disable iff (rst) s_wrap |=> s.counter_overflow_flag && s.count == CNT_ZERO;
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow flag missed at wrap");

  property p_cnt_max;
    @(posedge ref_clk) disable iff (rst) s.count <= CNT_TOP;
  endproperty
  a_cnt_max: assert property (p_cnt_max) else $error("counter above 254");

  property p_clear;
    @(posedge ref_clk) disable iff (rst) !s.counter_enable_clear |=> s.count == CNT_ZERO;
  endproperty
  a_clear: assert property (p_clear) else $error("counter not cleared");

  property p_reload;
    @(posedge ref_clk) disable iff (rst)
      !s.counter_enable_clear |=> s.prescale == ~$past(s.period_reload_value);
  endproperty
  a_reload: assert property (p_reload) else $error("prescaler not reloaded");

  property p_step;
    @(posedge ref_clk) disable iff (rst)
      s.counter_enable_clear && !tick && $stable(s.counter_enable_clear) |=> $stable(s.count);
  endproperty
  a_step: assert property (p_step) else $error("counter moved without prescaler tick");

  property p_low_const;
    @(posedge ref_clk) disable iff (rst)
      s.channel0_compare == CMP_LOW ##1 s.channel0_compare == CMP_LOW |-> !s.pulse[0];
  endproperty
  a_low_const: assert property (p_low_const) else $error("compare 00h not low");

  property p_match_low;
    @(posedge ref_clk) disable iff (rst)
      s.counter_enable_clear && s.count == s.channel1_compare && s.count != CNT_ZERO
      && s.channel1_compare != CMP_HIGH |=> !s.pulse[1];
  endproperty
  a_match_low: assert property (p_match_low) else $error("match did not drive low");

  property p_zero_high;
    @(posedge ref_clk) disable iff (rst)
      s.count == CNT_ZERO && s.channel0_compare != CMP_LOW |=> s.pulse[0];
  endproperty
  a_zero_high: assert property (p_zero_high) else $error("zero did not drive high");

  property p_pin_oe;
    @(posedge ref_clk) disable iff (rst)
      1'b1 |=> pulse_oe == $past({s.channel1_output_enable, s.channel0_output_enable});
  endproperty
  a_pin_oe: assert property (p_pin_oe) else $error("pin enable mismatch");

  ////////////////////////////////////////////////////////////////////////////
  // flag and interrupt; a clear only loses against a wrap in the same cycle
  sequence s_ovf_clear;
    wr_ctl && !new_ctl[CTL_OVF] && !wrap;
  endsequence

  property p_ovf_hold;
    @(posedge ref_clk) disable iff (rst)
      s.counter_overflow_flag && !wr_ctl |=> s.counter_overflow_flag;
  endproperty
  a_ovf_hold: assert property (p_ovf_hold) else $error("overflow flag lost without clear");

  property p_ovf_clear;
    @(posedge ref_clk) disable iff (rst)
      s_ovf_clear |=> !s.counter_overflow_flag;
  endproperty
  a_ovf_clear: assert property (p_ovf_clear) else $error("overflow flag not cleared");

  property p_ovf_only_wrap;
    @(posedge ref_clk) disable iff (rst)
      !s.counter_overflow_flag && !wrap |=> !s.counter_overflow_flag;
  endproperty
  a_ovf_only_wrap: assert property (p_ovf_only_wrap) else $error("overflow flag set without wrap");

  property p_stat_set;
    @(posedge ref_clk) disable iff (rst)
      s_wrap |=> s.irq_status;
  endproperty
  a_stat_set: assert property (p_stat_set) else $error("status bit missed at wrap");

  property p_irq_level;
    @(posedge ref_clk) disable iff (rst)
      1'b1 |=> irq == $past(s.irq_status && s.irq_mask);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt level mismatch");

  ////////////////////////////////////////////////////////////////////////////
  // prescaler and counter stepping
  sequence s_count_step;
    tick && !wrap;
  endsequence

  property p_count_step;
    @(posedge ref_clk) disable iff (rst)
      s_count_step |=> s.count == $past(s.count) + 8'h01;
  endproperty
  a_count_step: assert property (p_count_step) else $error("counter did not step by one");

  property p_tick_reload;
    @(posedge ref_clk) disable iff (rst)
      tick |=> s.prescale == ~$past(s.period_reload_value);
  endproperty
  a_tick_reload: assert property (p_tick_reload) else $error("prescaler not reloaded on expiry");

  property p_prescale_step;
    @(posedge ref_clk) disable iff (rst)
      s.counter_enable_clear && !tick |=> s.prescale == $past(s.prescale) + 8'h01;
  endproperty
  a_prescale_step: assert property (p_prescale_step) else $error("prescaler did not step");

  ////////////////////////////////////////////////////////////////////////////
  // fixed levels need the compare stable a cycle, the output is registered
  sequence s_ch0_full;
    s.channel0_compare == CMP_HIGH ##1 s.channel0_compare == CMP_HIGH;
  endsequence

  sequence s_ch1_full;
    s.channel1_compare == CMP_HIGH ##1 s.channel1_compare == CMP_HIGH;
  endsequence

  sequence s_ch1_empty;
    s.channel1_compare == CMP_LOW ##1 s.channel1_compare == CMP_LOW;
  endsequence

  property p_ch0_high_const;
    @(posedge ref_clk) disable iff (rst)
      s_ch0_full |-> s.pulse[0];
  endproperty
  a_ch0_high_const: assert property (p_ch0_high_const) else $error("compare ffh not high on channel 0");

  property p_ch1_high_const;
    @(posedge ref_clk) disable iff (rst)
      s_ch1_full |-> s.pulse[1];
  endproperty
  a_ch1_high_const: assert property (p_ch1_high_const) else $error("compare ffh not high on channel 1");

  property p_ch1_low_const;
    @(posedge ref_clk) disable iff (rst)
      s_ch1_empty |-> !s.pulse[1];
  endproperty
  a_ch1_low_const: assert property (p_ch1_low_const) else $error("compare 00h not low on channel 1");

  property p_ch0_match_low;
    @(posedge ref_clk) disable iff (rst)
      s.counter_enable_clear && s.count == s.channel0_compare && s.count != CNT_ZERO |=> !s.pulse[0];
  endproperty
  a_ch0_match_low: assert property (p_ch0_match_low) else $error("match did not drive channel 0 low");

  property p_ch1_zero_high;
    @(posedge ref_clk) disable iff (rst)
      s.count == CNT_ZERO && s.channel1_compare != CMP_LOW |=> s.pulse[1];
  endproperty
  a_ch1_zero_high: assert property (p_ch1_zero_high) else $error("zero did not drive channel 1 high");

  property p_ch0_held_high;
    @(posedge ref_clk) disable iff (rst)
      !s.counter_enable_clear && s.channel0_compare != CMP_LOW |=> s.pulse[0];
  endproperty
  a_ch0_held_high: assert property (p_ch0_held_high) else $error("channel 0 not high while cleared");

  property p_ch1_held_high;
    @(posedge ref_clk) disable iff (rst)
      !s.counter_enable_clear && s.channel1_compare != CMP_LOW |=> s.pulse[1];
  endproperty
  a_ch1_held_high: assert property (p_ch1_held_high) else $error("channel 1 not high while cleared");

  ////////////////////////////////////////////////////////////////////////////
  // register read path and pins
  property p_read_period;
    @(posedge ref_clk) disable iff (rst)
      psel && !penable && !pwrite && paddr == ADDR_PERIOD
      |=> pready && prdata == {24'h00_0000, $past(s.period_reload_value)};
  endproperty
  a_read_period: assert property (p_read_period) else $error("reload value not read back");

  property p_pin_out;
    @(posedge ref_clk) disable iff (rst)
      1'b1 |=> pulse_out == $past(s.pulse);
  endproperty
  a_pin_out: assert property (p_pin_out) else $error("pin level mismatch");

endmodule
`default_nettype wire

// ---- pwm_pkg.sv ----
`default_nettype none
package pwm_pkg;

  // register byte addresses
  localparam logic [7:0] ADDR_CONTROL  = 8'hbc;
  localparam logic [7:0] ADDR_PERIOD   = 8'hc0;
  localparam logic [7:0] ADDR_CMP0     = 8'hc4;
  localparam logic [7:0] ADDR_CMP1     = 8'hc8;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'hcc;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'hd0;

  // control register fields
  localparam int CTL_OE0  = 0;
  localparam int CTL_OE1  = 1;
  localparam int CTL_EN   = 2;
  localparam int CTL_OVF  = 3;

  // interrupt status fields
  localparam int IRQ_OVF  = 0;

  // counter limits and special compare values
  localparam logic [7:0] CNT_TOP    = 8'hfe;
  localparam logic [7:0] CNT_ZERO   = 8'h00;
  localparam logic [7:0] CMP_LOW    = 8'h00;
  localparam logic [7:0] CMP_HIGH   = 8'hff;

  // reset values
  localparam logic [7:0] CTL_RESET    = 8'h00;
  localparam logic [7:0] PERIOD_RESET = 8'h00;
  localparam logic [7:0] CMP_RESET    = 8'h00;

  localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic [7:0] paddr;
    logic       psel;
    logic       penable;
    logic       pwrite;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic        counter_overflow_flag;
    logic        counter_enable_clear;
    logic        channel1_output_enable;
    logic        channel0_output_enable;
    logic [7:0]  period_reload_value;
    logic [7:0]  channel0_compare;
    logic [7:0]  channel1_compare;
    logic [7:0]  prescale;
    logic [7:0]  count;
    logic [1:0]  pulse;
    logic [1:0]  pin_out;
    logic [1:0]  pin_oe;
    logic        irq_status;
    logic        irq_mask;
    logic        irq;
    logic        pready;
    logic [31:0] prdata;
  } pwm_state_t;

endpackage
`default_nettype wire

// ---- pulse_load.sv ----
`timescale 1ns/100ps
`default_nettype none
module pulse_load (
  // clock
  input  wire logic       ref_clk,
  // modulator pins
  input  wire logic [1:0] pulse_out,
  input  wire logic [1:0] pulse_oe,
  // level seen by the load
  output var  logic [1:0] pin
);
  logic [1:0] last = 2'b00;

  ////////////////////////////////////////////////////////////////
  // released pin toggles, so a lost enable never looks like a level
  always_comb begin
    pin = (pulse_oe & pulse_out) | (~pulse_oe & ~last);
  end

  always @(posedge ref_clk) begin
    last <= pin;
  end
endmodule
`default_nettype wire

// ---- test_dual_pulse_modulator.sv ----
`timescale 1ns/100ps
`default_nettype none
module test_dual_pulse_modulator;
  import pwm_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rst     = 1'b1;
  apb_req_t    req     = '0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic [1:0]  pulse_out;
  logic [1:0]  pulse_oe;
  logic [1:0]  pin;
  int          failures    = 0;
  int          comparisons = 0;
  int          cycles      = 0;
  int          hi0;
  int          hi1;
  int          win;
  logic [31:0] q;
  logic [31:0] model [logic [7:0]];
  logic [7:0]  per;
  logic [7:0]  vals [5];
  logic [7:0]  addrs [7];

  dual_pulse_modulator dual_pulse_modulator_inst (
    .ref_clk(ref_clk), .rst(rst), .paddr(req.paddr), .psel(req.psel), .penable(req.penable),
    .pwrite(req.pwrite), .pwdata(req.pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pulse_out(pulse_out), .pulse_oe(pulse_oe), .irq(irq));
  pulse_load pulse_load_inst (.ref_clk(ref_clk), .pulse_out(pulse_out), .pulse_oe(pulse_oe), .pin(pin));

  ////////////////////////////////////////////////////////////////
  initial forever #2 ref_clk = ~ref_clk;

  task automatic wrap_up();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // bound well above the longest run of the sequence
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      $display("CHECK FAILED at %0t: run did not finish", $time);
      wrap_up();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
    @(posedge ref_clk);
    req.penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    q = prdata;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
    if (w) model[a] = d;
  endtask

  // window of one full output period counts high cycles at the load
  task automatic measure();
    hi0 = 0;
    hi1 = 0;
    repeat (win) begin
      @(posedge ref_clk);
      hi0 += int'(pin[0] === 1'b1);
      hi1 += int'(pin[1] === 1'b1);
    end
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h717678ed));
    addrs = '{ADDR_CONTROL, ADDR_PERIOD, ADDR_CMP0, ADDR_CMP1, ADDR_IRQ_STAT, ADDR_IRQ_MASK, 8'hd4};
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    foreach (addrs[i]) begin
      apb(1'b0, addrs[i], DATA_ZERO);
      check(q, DATA_ZERO);
    end
    $display("test reset done");
    per = 8'($urandom_range(3, 0));
    vals = '{8'($urandom_range(254, 1)), 8'h00, 8'hff, 8'h01, 8'($urandom_range(254, 1))};
    win = 255 * (int'(per) + 1);
    apb(1'b1, ADDR_PERIOD, {24'h0, per});
    apb(1'b0, ADDR_PERIOD, DATA_ZERO);
    check(q, model[ADDR_PERIOD]);
    apb(1'b1, ADDR_CONTROL, 32'h07);
    foreach (vals[i]) begin
      apb(1'b1, ADDR_CMP0, {24'h0, vals[i]});
      apb(1'b1, ADDR_CMP1, {24'h0, 8'hff - vals[i]});
      repeat (win + 8) @(posedge ref_clk);
      measure();
      check(32'(hi0), 32'(vals[i]) * (32'(per) + 1));
      check(32'(hi1), 32'(8'hff - vals[i]) * (32'(per) + 1));
    end
    apb(1'b0, ADDR_CMP0, DATA_ZERO);
    check(q, model[ADDR_CMP0]);
    $display("test duty done");
    apb(1'b0, ADDR_CONTROL, DATA_ZERO);
    check(q, 32'h0f);
    // second write clears a flag that a wrap set in the same cycle
    apb(1'b1, ADDR_CONTROL, 32'h03);
    apb(1'b1, ADDR_CONTROL, 32'h03);
    apb(1'b0, ADDR_CONTROL, DATA_ZERO);
    check(q, 32'h03);
    repeat (4) @(posedge ref_clk);
    check(32'(pin), 32'h3);
    // pins handed back as plain io, counter kept as timer
    apb(1'b1, ADDR_CONTROL, 32'h04);
    repeat (2) @(posedge ref_clk);
    check(32'(pulse_oe), DATA_ZERO);
    repeat (win - 30) @(posedge ref_clk);
    apb(1'b0, ADDR_CONTROL, DATA_ZERO);
    check(q, 32'h04);
    repeat (40) @(posedge ref_clk);
    apb(1'b0, ADDR_CONTROL, DATA_ZERO);
    check(q, 32'h0c);
    $display("test timer done");
    apb(1'b1, ADDR_CONTROL, DATA_ZERO);
    apb(1'b0, ADDR_IRQ_STAT, DATA_ZERO);
    check(q, 32'h1);
    check(32'(irq), DATA_ZERO);
    apb(1'b1, ADDR_IRQ_MASK, 32'h1);
    repeat (2) @(posedge ref_clk);
    check(32'(irq), 32'h1);
    apb(1'b1, ADDR_IRQ_STAT, 32'h1);
    repeat (2) @(posedge ref_clk);
    check(32'(irq), DATA_ZERO);
    $display("test interrupt done");
    // reset in mid-run with the counter running and both pins driven
    apb(1'b1, ADDR_CONTROL, 32'h07);
    repeat (20) @(posedge ref_clk);
    rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    check(32'({pulse_out, pulse_oe, irq}), DATA_ZERO);
    foreach (addrs[i]) begin
      apb(1'b0, addrs[i], DATA_ZERO);
      check(q, DATA_ZERO);
    end
    check(32'(pslverr), DATA_ZERO);
    $display("test second reset done");
    wrap_up();
  end
endmodule
`default_nettype wire
